// ==== src/cgl_pkg.sv ====
/*
 * package for the camera gpio line control block: register offsets,
 * field positions, reset values, source codes and timing constants.
 * assumes a 200 MHz device clock and a 32-bit classic wishbone slave.
 */
package cgl_pkg;

	// ==========================================================
	// geometry and clock
	localparam int NUM_LINES    = 4;
	localparam int NUM_USER     = 4;
	localparam int NUM_LB       = 2;
	localparam int NUM_CNT      = 2;
	localparam int CLK_MHZ      = 200;
	localparam int CLK_PER_US   = CLK_MHZ;
	localparam int WIDTH_US_W   = 16;
	localparam int CNT_W        = 24;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFF_LINE_PICKER   = 8'h00;
	localparam logic [7:0] OFF_LINE_CTRL     = 8'h04;
	localparam logic [7:0] OFF_LINE_LEVEL    = 8'h08;
	localparam logic [7:0] OFF_ALL_LEVELS    = 8'h0C;
	localparam logic [7:0] OFF_FILTER_CHOICE = 8'h10;
	localparam logic [7:0] OFF_FILTER_US     = 8'h14;
	localparam logic [7:0] OFF_SOFT_PICKER   = 8'h18;
	localparam logic [7:0] OFF_SOFT_LEVEL    = 8'h1C;
	localparam logic [7:0] OFF_ALL_SOFT      = 8'h20;
	localparam logic [7:0] OFF_CIRCUIT_TYPE  = 8'h24;

	// line control field positions
	localparam int CTRL_DIR_BIT  = 0;
	localparam int CTRL_FLIP_BIT = 1;
	localparam int CTRL_SRC_LSB  = 4;
	localparam int CTRL_SEL_LSB  = 8;

	// filter choice codes
	localparam logic FILT_GLITCH = 1'b0;
	localparam logic FILT_BOUNCE = 1'b1;

	// output source codes
	typedef enum logic [2:0] {
		CGL_SRC_LINE     = 3'h0,
		CGL_SRC_USER     = 3'h1,
		CGL_SRC_COUNTER  = 3'h2,
		CGL_SRC_LOGIC    = 3'h3,
		CGL_SRC_EXPOSURE = 3'h4,
		CGL_SRC_FTRIG    = 3'h5
	} cgl_src_t;

	// circuit type codes
	localparam logic [1:0] CIRC_TRISTATE  = 2'h0;
	localparam logic [1:0] CIRC_OPTO      = 2'h1;
	localparam logic [1:0] CIRC_OPENDRAIN = 2'h2;

	// per-line configuration carried to the output mux
	typedef struct packed {
		logic       dir_out;
		logic       flip;
		cgl_src_t   src;
		logic [1:0] sel;
	} cgl_line_cfg_t;

	// reset values
	localparam logic [15:0] RST_FILTER_US = 16'h0000;

endpackage : cgl_pkg

// ==== src/cgl_filter.sv ====
/*
 * one line's input filter: glitch rejection followed by bounce
 * suppression, each with its own width in device clock cycles.
 * assumes the input is already synchronised to clk_i.
 */
`timescale 1ns/1ps
module cgl_filter #(
	parameter int CNT_W = cgl_pkg::CNT_W
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             din_i,
	input  wire logic [CNT_W-1:0] glitch_cycles_i,
	input  wire logic [CNT_W-1:0] bounce_cycles_i,
	output logic                  dout_o
);

	// ==========================================================
	// glitch rejection
	logic             glitch_q;
	logic [CNT_W-1:0] gcnt;
	logic             bounce_q;
	logic [CNT_W-1:0] bcnt;

	// new level accepted only after stable for the full width
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			glitch_q <= 1'b0;
			gcnt     <= '0;
		end else if (din_i == glitch_q) begin
			gcnt <= '0;
		end else if (gcnt + 1'b1 >= glitch_cycles_i) begin
			glitch_q <= din_i;
			gcnt     <= '0;
		end else begin
			gcnt <= gcnt + 1'b1;
		end
	end

	// ==========================================================
	// bounce suppression fed by the glitch stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bounce_q <= 1'b0;
			bcnt     <= '0;
		end else if (bcnt != '0) begin
			bcnt <= bcnt - 1'b1; // changes ignored while counting
		end else if (glitch_q != bounce_q) begin
			bounce_q <= glitch_q; // first edge passes at once
			bcnt     <= bounce_cycles_i;
		end
	end

	assign dout_o = bounce_q;

endmodule // cgl_filter

// ==== src/cgl_gpio.sv ====
/*
 * camera gpio line control: four lines with direction, polarity flip,
 * filters, selectable output sources and user outputs, reached over a
 * classic wishbone slave.
 * assumes pins are sampled asynchronously and the camera core supplies
 * counter, logic block, exposure and frame-trigger status on clk_i.
 */
// Notes on behaviour
// - four lines; picker routes per-line settings
// - direction per line; drive only as output
// - polarity flip inverts selected line sense
// - level readback returns selected line state
// - packed word, line n at bit n
// - per-line filter choice and microsecond widths
// - glitch filter accepts after full stable width
// - bounce filter passes first edge, then holds
// - glitch stage feeds bounce stage
// - source choice matters only in output mode
// - sources: loopback, user, counter, logic block
// - exposure source high while sensor exposes
// - frame trigger source high while ready
// - soft picker chooses bit; level sets it
// - packed user word writes/reads all outputs
// - read-only circuit type per line
// - open drain only pulls low
`timescale 1ns/1ps
module cgl_gpio #(
	parameter int          NUM_LINES = cgl_pkg::NUM_LINES,
	parameter logic [7:0]  CIRC_TYPES = 8'hAA
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// wishbone slave
	input  wire logic                 cyc_i,
	input  wire logic                 stb_i,
	input  wire logic                 we_i,
	input  wire logic [7:0]           adr_i,
	input  wire logic [3:0]           sel_i,
	input  wire logic [31:0]          dat_i,
	output logic      [31:0]          dat_o,
	output logic                      ack_o,
	// camera core status
	input  wire logic [1:0]           counter_active_i,
	input  wire logic [1:0]           logic_block_i,
	input  wire logic                 exposure_active_i,
	input  wire logic                 frame_trig_wait_i,
	// pins
	input  wire logic [NUM_LINES-1:0] line_pin_i,
	output logic      [NUM_LINES-1:0] line_pin_o,
	output logic      [NUM_LINES-1:0] line_pin_oe_o
);

	// ==========================================================
	// elaboration checks: refuse values the logic cannot serve
	if (NUM_LINES != cgl_pkg::NUM_LINES) begin : g_bad_lines
		$error("cgl_gpio serves exactly four lines");
	end
	// the widest microsecond value must fit the filter counters
	if (64'(cgl_pkg::CLK_PER_US) * 64'h0000_0000_0000_FFFF >=
		(64'h0000_0000_0000_0001 << cgl_pkg::CNT_W)) begin : g_bad_cnt
		$error("cgl_gpio filter counter too narrow");
	end
	// code 3 names no circuit type
	for (genvar c = 0; c < NUM_LINES; c++) begin : g_circ
		if (CIRC_TYPES[2*c +: 2] == 2'h3) begin : g_bad_circ
			$error("cgl_gpio circuit type code 3 is unused");
		end
	end

	// ==========================================================
	// configuration state
	logic [1:0]                  line_picker;
	cgl_pkg::cgl_line_cfg_t      cfg [NUM_LINES];
	logic [NUM_LINES-1:0]        filt_choice;
	logic [15:0]                 glitch_us [NUM_LINES];
	logic [15:0]                 bounce_us [NUM_LINES];
	logic [1:0]                  soft_picker;
	logic [cgl_pkg::NUM_USER-1:0] soft_out;

	// ==========================================================
	// pin synchronisers and filters
	logic [NUM_LINES-1:0] sync1;
	logic [NUM_LINES-1:0] sync2;
	logic [NUM_LINES-1:0] sync3;
	logic [NUM_LINES-1:0] pin_clean;
	logic [NUM_LINES-1:0] filtered;
	logic [NUM_LINES-1:0] level;

	// three-stage synchroniser; accept once stages two and three agree
	// the agree stage holds the old level while a late sample settles
	// pin_clean resets low; a high pin shows four cycles after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1     <= '0;
			sync2     <= '0;
			sync3     <= '0;
			pin_clean <= '0;
		end else begin
			sync1 <= line_pin_i;
			sync2 <= sync1;
			sync3 <= sync2;
			for (int i = 0; i < NUM_LINES; i++) begin
				if (sync2[i] == sync3[i])
					pin_clean[i] <= sync3[i];
			end
		end
	end

	// microsecond widths become cycle counts
	function automatic logic [cgl_pkg::CNT_W-1:0] us_to_cycles(
		input logic [15:0] us
	);
		logic [31:0] prod;
		prod = 32'(us) * 32'(cgl_pkg::CLK_PER_US);
		return prod[cgl_pkg::CNT_W-1:0];
	endfunction

	// one filter pair per line
	for (genvar g = 0; g < NUM_LINES; g++) begin : g_filt
		cgl_filter #(
			.CNT_W(cgl_pkg::CNT_W)
		) u_filt (
			.clk_i           (clk_i),
			.rst_i           (rst_i),
			.din_i           (pin_clean[g]),
			.glitch_cycles_i (us_to_cycles(glitch_us[g])),
			.bounce_cycles_i (us_to_cycles(bounce_us[g])),
			.dout_o          (filtered[g])
		);
	end

	// ==========================================================
	// output source selection and pin drive
	logic [NUM_LINES-1:0] src_val;
	logic [NUM_LINES-1:0] next_drive;

	// source mux; other lines' levels give loopback
	// counter and logic block sources use only the low index bit
	always_comb begin
		for (int i = 0; i < NUM_LINES; i++) begin
			case (cfg[i].src)
				cgl_pkg::CGL_SRC_LINE:     src_val[i] = level[cfg[i].sel];
				cgl_pkg::CGL_SRC_USER:     src_val[i] = soft_out[cfg[i].sel];
				cgl_pkg::CGL_SRC_COUNTER:  src_val[i] =
					counter_active_i[cfg[i].sel[0]];
				cgl_pkg::CGL_SRC_LOGIC:    src_val[i] =
					logic_block_i[cfg[i].sel[0]];
				cgl_pkg::CGL_SRC_EXPOSURE: src_val[i] = exposure_active_i;
				cgl_pkg::CGL_SRC_FTRIG:    src_val[i] = frame_trig_wait_i;
				default:                   src_val[i] = 1'b0;
			endcase
			// flip applies to the driven sense as well
			next_drive[i] = src_val[i] ^ cfg[i].flip;
		end
	end

	// open drain: pull low only, high left to external pull-up
	// registering oe costs a cycle but keeps mux glitches off the pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_pin_o    <= '0;
			line_pin_oe_o <= '0;
		end else begin
			line_pin_o <= '0;
			for (int i = 0; i < NUM_LINES; i++) begin
				// drive only in output mode, and only the low level
				line_pin_oe_o[i] <= cfg[i].dir_out & ~next_drive[i];
			end
		end
	end

	// live level: filtered pin, inverted if flipped
	// an output line reads back its own pin through the filters
	always_comb begin
		for (int i = 0; i < NUM_LINES; i++)
			level[i] = filtered[i] ^ cfg[i].flip;
	end

	// ==========================================================
	// wishbone register file
	logic        req;
	logic        wr;
	logic [31:0] rdata;
	logic [1:0]  lp;

	// single-cycle answer; ack drops in the cycle after it was given
	// ack and dat_o stay on flops, so every access costs one wait cycle
	assign req = cyc_i & stb_i & ~ack_o;
	assign wr  = req & we_i & sel_i[0];
	assign lp  = line_picker;

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= req;
	end

	// line picker routes every per-line write
	always_ff @(posedge clk_i) begin
		if (rst_i)
			line_picker <= 2'h0;
		else if (wr && adr_i == cgl_pkg::OFF_LINE_PICKER)
			line_picker <= dat_i[1:0];
	end

	// soft output picker
	always_ff @(posedge clk_i) begin
		if (rst_i)
			soft_picker <= 2'h0;
		else if (wr && adr_i == cgl_pkg::OFF_SOFT_PICKER)
			soft_picker <= dat_i[1:0];
	end

	// direction, flip and source land in the picked line only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_LINES; i++)
				cfg[i] <= '{dir_out: 1'b0, flip: 1'b0,
				           src: cgl_pkg::CGL_SRC_LINE, sel: 2'h0};
		end else if (wr && adr_i == cgl_pkg::OFF_LINE_CTRL) begin
			cfg[lp].dir_out <= dat_i[cgl_pkg::CTRL_DIR_BIT];
			cfg[lp].flip    <= dat_i[cgl_pkg::CTRL_FLIP_BIT];
			cfg[lp].src     <= cgl_pkg::cgl_src_t'(
				dat_i[cgl_pkg::CTRL_SRC_LSB +: 3]);
			cfg[lp].sel     <= dat_i[cgl_pkg::CTRL_SEL_LSB +: 2];
		end
	end

	// filter type choice per line
	always_ff @(posedge clk_i) begin
		if (rst_i)
			filt_choice <= '0;
		else if (wr && adr_i == cgl_pkg::OFF_FILTER_CHOICE)
			filt_choice[lp] <= dat_i[0];
	end

	// width lands in the chosen filter of the picked line
	// a new width applies at once to the glitch compare; a running bounce count keeps its old load
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_LINES; i++) begin
				glitch_us[i] <= cgl_pkg::RST_FILTER_US;
				bounce_us[i] <= cgl_pkg::RST_FILTER_US;
			end
		end else if (wr && adr_i == cgl_pkg::OFF_FILTER_US) begin
			if (filt_choice[lp] == cgl_pkg::FILT_GLITCH)
				glitch_us[lp] <= dat_i[15:0];
			else
				bounce_us[lp] <= dat_i[15:0];
		end
	end

	// user outputs: single bit through picker, or whole word
	// bit and word writes use distinct offsets, so they never collide
	always_ff @(posedge clk_i) begin
		if (rst_i)
			soft_out <= '0;
		else if (wr && adr_i == cgl_pkg::OFF_SOFT_LEVEL)
			soft_out[soft_picker] <= dat_i[0];
		else if (wr && adr_i == cgl_pkg::OFF_ALL_SOFT)
			soft_out <= dat_i[cgl_pkg::NUM_USER-1:0];
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rdata = 32'h0000_0000;
		case (adr_i)
			cgl_pkg::OFF_LINE_PICKER:   rdata[1:0] = line_picker;
			cgl_pkg::OFF_LINE_CTRL: begin
				rdata[cgl_pkg::CTRL_DIR_BIT]      = cfg[lp].dir_out;
				rdata[cgl_pkg::CTRL_FLIP_BIT]     = cfg[lp].flip;
				rdata[cgl_pkg::CTRL_SRC_LSB +: 3] = cfg[lp].src;
				rdata[cgl_pkg::CTRL_SEL_LSB +: 2] = cfg[lp].sel;
			end
			cgl_pkg::OFF_LINE_LEVEL:    rdata[0] = level[lp];
			cgl_pkg::OFF_ALL_LEVELS:    rdata[NUM_LINES-1:0] = level;
			cgl_pkg::OFF_FILTER_CHOICE: rdata[0] = filt_choice[lp];
			cgl_pkg::OFF_FILTER_US:
				rdata[15:0] = (filt_choice[lp] == cgl_pkg::FILT_GLITCH) ?
					glitch_us[lp] : bounce_us[lp];
			cgl_pkg::OFF_SOFT_PICKER:   rdata[1:0] = soft_picker;
			cgl_pkg::OFF_SOFT_LEVEL:    rdata[0] = soft_out[soft_picker];
			cgl_pkg::OFF_ALL_SOFT:
				rdata[cgl_pkg::NUM_USER-1:0] = soft_out;
			cgl_pkg::OFF_CIRCUIT_TYPE:
				rdata[1:0] = CIRC_TYPES[2*lp +: 2];
			default:                    rdata = 32'h0000_0000;
		endcase
	end

	// read data registered with ack
	always_ff @(posedge clk_i) begin
		if (rst_i)
			dat_o <= 32'h0000_0000;
		else if (req)
			dat_o <= rdata;
	end

endmodule // cgl_gpio

// ==== tb/cgl_gpio_checker.sv ====
/* assertions on the ports of cgl_gpio.
   assumes a classic wishbone master that holds adr until ack. */
`timescale 1ns/1ps
module cgl_gpio_checker #(
	parameter int         NUM_LINES  = 4,
	parameter logic [7:0] CIRC_TYPES = 8'hAA
) (
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	input wire logic                 cyc_i,
	input wire logic                 stb_i,
	input wire logic                 we_i,
	input wire logic [7:0]           adr_i,
	input wire logic [3:0]           sel_i,
	input wire logic [31:0]          dat_i,
	input wire logic [31:0]          dat_o,
	input wire logic                 ack_o,
	input wire logic [1:0]           counter_active_i,
	input wire logic [1:0]           logic_block_i,
	input wire logic                 exposure_active_i,
	input wire logic                 frame_trig_wait_i,
	input wire logic [NUM_LINES-1:0] line_pin_i,
	input wire logic [NUM_LINES-1:0] line_pin_o,
	input wire logic [NUM_LINES-1:0] line_pin_oe_o
);
	// ==========================================================
	// port checks: one-cycle ack, no high drive, released in reset; level, filter choice, soft word and circuit reads keep unused high bits clear
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	wire rd = ack_o && !we_i;
	chk_ack_one_pulse:
	assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("ack not a single pulse");
	chk_never_drive_high:
	assert property (line_pin_o == '0) else $error("pin driven high");
	chk_reset_released:
	assert property (disable iff (1'b0) rst_i |=> line_pin_oe_o == '0)
		else $error("pin pulled after reset");
	chk_level_one_bit:
	assert property (rd && adr_i == 8'h08 |-> dat_o[31:1] == '0)
		else $error("level read wide");
	chk_word_width:
	assert property (rd && adr_i == 8'h0C |-> dat_o[31:NUM_LINES] == '0)
		else $error("level word wide");
	chk_filter_choice:
	assert property (rd && adr_i == 8'h10 |-> dat_o[31:1] == '0)
		else $error("filter choice wide");
	chk_soft_word:
	assert property (rd && adr_i == 8'h20 |-> dat_o[31:4] == '0)
		else $error("soft word wide");
	chk_circuit_code:
	assert property (rd && adr_i == 8'h24 |-> dat_o[31:2] == '0
		&& dat_o[1:0] != 2'h3) else $error("bad circuit code");
	cover property (rd && adr_i == 8'h0C && dat_o != '0);
	cover property ($rose(line_pin_oe_o[0]));
	cover property (ack_o && we_i && adr_i == 8'h20);
endmodule // cgl_gpio_checker

bind cgl_gpio cgl_gpio_checker #(.NUM_LINES(NUM_LINES),
	.CIRC_TYPES(CIRC_TYPES)) chk_i (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.counter_active_i(counter_active_i), .logic_block_i(logic_block_i),
	.exposure_active_i(exposure_active_i),
	.frame_trig_wait_i(frame_trig_wait_i), .line_pin_i(line_pin_i),
	.line_pin_o(line_pin_o), .line_pin_oe_o(line_pin_oe_o));

// ==== tb/cgl_ext_model.sv ====
/* far side of the lines: pull-ups plus optional switches.
   assumes oe high means the device pulls the pin low. */
`timescale 1ns/1ps
module cgl_ext_model (
	input  wire logic [3:0] oe_i,
	input  wire logic [3:0] drv_en_i,
	input  wire logic [3:0] drv_lvl_i,
	output logic      [3:0] pin_o
);
	// ==========================================================
	// wired-and: released lines float high through the pull-up
	assign pin_o = ~oe_i & (~drv_en_i | drv_lvl_i);
endmodule // cgl_ext_model

// ==== tb/tb_top.sv ====
/* bench for cgl_gpio: wishbone master, pin model, reference values.
   assumes a 200 MHz clock and pull-ups on every line. */
`timescale 1ns/1ps
module tb_top;
	logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [7:0]  adr = 0;
	logic [31:0] wd = 0, rdat, q;
	logic        ack, v, f;
	logic [1:0]  cnt = 0, lb = 0;
	logic        expo = 0, ftw = 0;
	logic [3:0]  pin, oe, po, den = 0, dlv = 0;
	logic [3:0]  sel = 4'hF;
	int          err_count = 0, check_count = 0, sw, k;
	always #2.5 clk_i = ~clk_i;
	cgl_gpio cgl_gpio_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd),
		.dat_o(rdat), .ack_o(ack), .counter_active_i(cnt),
		.logic_block_i(lb), .exposure_active_i(expo),
		.frame_trig_wait_i(ftw), .line_pin_i(pin), .line_pin_o(po),
		.line_pin_oe_o(oe));
	cgl_ext_model cgl_ext_model_i (.oe_i(oe), .drv_en_i(den),
		.drv_lvl_i(dlv), .pin_o(pin));
	// ==========================================================
	// shared tasks
	task automatic chk(input string s, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one classic cycle; bounded wait for ack
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 0;
		stb <= 0;
		if (n >= 20) begin
			err_count++;
			print_verdict();
		end
	endtask
	task automatic lv(input logic e);
		wb(0, 8'h08, 0);
		chk("level", e, q);
	endtask
	initial begin
		#400000;
		err_count++;
		print_verdict();
	end
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(67758));
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		sw = $urandom % 16;
		wb(1, 8'h20, sw);
		wb(0, 8'h20, 0);
		chk("soft word", sw, q);
		wb(1, 8'h18, 2);
		wb(1, 8'h1C, 1);
		sw = sw | 4;
		wb(0, 8'h20, 0);
		chk("soft bit", sw, q);
		// a write without its low byte lane must leave the word alone
		sel <= 4'h0;
		wb(1, 8'h20, ~sw);
		sel <= 4'hF;
		wb(0, 8'h20, 0);
		chk("masked write", sw, q);
		$display("test soft done");
		// every source on line 0; line 1 is the loopback input
		wb(1, 8'h00, 0);
		for (int s = 0; s < 6; s++) begin
			k = (s == 0) ? 1 : $urandom % 4;
			f = 1'($urandom);
			{cnt, lb, expo, ftw} <= 6'($urandom);
			den[1] <= 1;
			dlv[1] <= 1'($urandom);
			wb(1, 8'h04, 1 | f << 1 | s << 4 | k << 8);
			repeat (12) @(posedge clk_i);
			case (s)
				0: v = dlv[1];
				1: v = sw[k];
				2: v = cnt[k%2];
				3: v = lb[k%2];
				4: v = expo;
				default: v = ftw;
			endcase
			chk("oe src", !(v ^ f), oe[0]);
			lv(v);
		end
		// input mode: exposure with flip would pull low if driven
		expo <= 1;
		wb(1, 8'h04, 2 | 4 << 4);
		repeat (3) @(posedge clk_i);
		chk("oe input", 0, oe[0]);
		den <= 4'hF;
		dlv <= 4'($urandom);
		repeat (12) @(posedge clk_i);
		wb(0, 8'h0C, 0);
		chk("all levels", dlv ^ 4'h1, q);
		$display("test direction done");
		// glitch rejection on line 2, 1 us = 200 cycles
		wb(1, 8'h00, 2);
		wb(1, 8'h14, 1);
		dlv[2] <= 0;
		repeat (300) @(posedge clk_i);
		dlv[2] <= 1;
		repeat (100) @(posedge clk_i);
		dlv[2] <= 0;
		repeat (300) @(posedge clk_i);
		lv(0);
		dlv[2] <= 1;
		repeat (150) @(posedge clk_i);
		lv(0);
		repeat (100) @(posedge clk_i);
		lv(1);
		$display("test glitch done");
		// bounce suppression on line 3
		wb(1, 8'h00, 3);
		wb(1, 8'h10, 1);
		wb(1, 8'h14, 1);
		dlv[3] <= 0;
		repeat (300) @(posedge clk_i);
		dlv[3] <= 1;
		repeat (20) @(posedge clk_i);
		lv(1);
		dlv[3] <= 0;
		repeat (60) @(posedge clk_i);
		lv(1);
		repeat (250) @(posedge clk_i);
		lv(0);
		$display("test bounce done");
		for (int l = 0; l < 4; l++) begin
			wb(1, 8'h00, l);
			wb(0, 8'h24, 0);
			chk("circuit", cgl_pkg::CIRC_OPENDRAIN, q);
		end
		wb(0, 8'h40, 0);
		chk("unmapped", 0, q);
		$display("test map done");
		print_verdict();
	end
endmodule // tb_top
